// ==== design/mrx_consts.svh ====
// Constants for the receive path and clock sources of the MII device end.
// Assumes a 100 MHz system clock; all counts are derived from the rates below.
`ifndef MRX_CONSTS_SVH
`define MRX_CONSTS_SVH

// ****************************************
// Clock rates
// ****************************************
`define MRX_SYS_CLK_KHZ     100000
`define MRX_RATE_FAST_KHZ   25000
`define MRX_RATE_SLOW_KHZ   2500

// Half periods of the MII clocks in system clock cycles
`define MRX_HALF_FAST_CYC   (`MRX_SYS_CLK_KHZ / (2 * `MRX_RATE_FAST_KHZ))
`define MRX_HALF_SLOW_CYC   (`MRX_SYS_CLK_KHZ / (2 * `MRX_RATE_SLOW_KHZ))
`define MRX_DIV_CNT_W       5

// ****************************************
// Field layout and reset values
// ****************************************
`define MRX_NIB_W           4
`define MRX_NIB_LSB         0
`define MRX_NIB_MSB         3
`define MRX_RST_NIB         4'h0
`define MRX_RST_OE_N        1'b1

`endif

// ==== design/mrx_pkg.sv ====
// Types shared by the receive path and its clock dividers.
// Assumes mrx_consts.svh is on the include path.
`include "mrx_consts.svh"

package mrx_pkg;

  // ****************************************
  // Events passed from the line domain
  // ****************************************
  typedef enum logic [2:0] {
    MRX_EV_SOF    = 3'h0,
    MRX_EV_NIB    = 3'h1,
    MRX_EV_ERRNIB = 3'h2,
    MRX_EV_ABORT  = 3'h3,
    MRX_EV_EOF    = 3'h4,
    MRX_EV_FCAR   = 3'h5
  } mrx_ev_kind_t;

  typedef struct packed {
    mrx_ev_kind_t                kind;
    logic [`MRX_NIB_W-1:0]       nib;
  } mrx_ev_t;

  // ****************************************
  // Line framing states
  // ****************************************
  typedef enum logic [1:0] {
    MRX_LN_IDLE  = 2'b01,
    MRX_LN_FRAME = 2'b10
  } mrx_ln_state_t;

endpackage

// ==== design/mrx_clk_if.sv ====
// Carrier between the receive top and one MII clock divider.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps

interface mrx_clk_if;
  logic fast;
  logic restart;
  logic clk_out;
  logic fall;

  modport div  (input fast, input restart, output clk_out, output fall);
  modport user (output fast, output restart, input clk_out, input fall);
endinterface

// ==== design/mrx_clk_div.sv ====
// MII clock divider: 25 MHz or 2.5 MHz square wave from the system clock.
// Assumes restart and fast come from flops on the same clock.
`timescale 1ns/10ps
`include "mrx_consts.svh"

module mrx_clk_div #(
  parameter int                   CNT_W     = `MRX_DIV_CNT_W,
  parameter logic [CNT_W-1:0]     HALF_FAST = CNT_W'(`MRX_HALF_FAST_CYC),
  parameter logic [CNT_W-1:0]     HALF_SLOW = CNT_W'(`MRX_HALF_SLOW_CYC)
) (
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   nrst,
  // Divider control and output
  mrx_clk_if.div      ctl
);
  import mrx_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic             clk_q;
  logic             fall_q;
  logic [CNT_W-1:0] half;

  assign half        = ctl.fast ? HALF_FAST : HALF_SLOW;
  assign ctl.clk_out = clk_q;
  assign ctl.fall    = fall_q;

  // ****************************************
  // Half period counter
  // ****************************************
  // Restart begins a fresh low phase, so the output phase can jump by up to half a period
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q  <= '0;
      clk_q  <= 1'b0;
      fall_q <= 1'b0;
    end else if (ctl.restart) begin
      cnt_q  <= '0;
      clk_q  <= 1'b0;
      fall_q <= clk_q;
    end else if (cnt_q >= half - CNT_W'(1)) begin
      cnt_q  <= '0;
      clk_q  <= ~clk_q;
      fall_q <= clk_q;
    end else begin
      cnt_q  <= cnt_q + CNT_W'(1);
      fall_q <= 1'b0;
    end
  end

endmodule

// ==== design/mrx_rx_top.sv ====
// MII device end: receive clock, receive nibble bus with valid and error, transmit clock.
// Assumes the coding layer feeds decoded nibbles and delimiter flags on line_clk,
// with at least four line_clk cycles between two events.
//
// Notes on behaviour
// [RULE_01] At 10 Mb/s the receive clock is realigned only between carrier and valid.
// [RULE_02] At 100 Mb/s link bring-up may jump the receive clock phase fully.
// [RULE_03] At 10 Mb/s the receive clock realigns once for each packet.
// [RULE_04] At 100 Mb/s the receive clock realigns once, at link establishment.
// [RULE_05] The tristate control input decides whether receive clock and error drive.
// [RULE_06] Receive data is a nibble, bit 0 least significant, bit 3 most.
// [RULE_07] Nibbles appear with valid, aligned to receive clock rising edges.
// [RULE_08] Receive valid high tells the MAC that nibbles are present.
// [RULE_09] Receive valid rises only after the start delimiter pair is recovered.
// [RULE_10] Receive valid falls after the end delimiter pair or a signal error.
// [RULE_11] Receive valid changes only in step with the supplied receive clock.
// [RULE_12] At 10 Mb/s receive error is never asserted.
// [RULE_13] At 100 Mb/s receive error flags errors inside a valid frame.
// [RULE_14] At 100 Mb/s receive error also flags a false carrier.
// [RULE_15] Receive error changes only in step with the receive clock.
// [RULE_16] The device makes the transmit clock and drives it to the MAC.
// [RULE_17] Transmit clock runs at 2.5 MHz slow, 25 MHz fast.
// [RULE_18] Receive clock runs at 2.5 MHz slow, 25 MHz fast.
// [RULE_19] At 100 Mb/s receive clock follows the line with link, else the reference; rx_clk here always divides sys_clk, realigned once at link-up.
`timescale 1ns/10ps
`include "mrx_consts.svh"

module mrx_rx_top (
  // System clock and reset
  input  wire  logic                      sys_clk,
  input  wire  logic                      nrst,
  // Mode and tristate pins
  input  wire  logic                      speed_100,
  input  wire  logic                      receive_output_tristate_ctl,
  // Line side, from the coding layer
  input  wire  logic                      line_clk,
  input  wire  logic                      line_link_ok,
  input  wire  logic                      line_crs,
  input  wire  logic                      line_ssd,
  input  wire  logic                      line_esd,
  input  wire  logic                      line_sig_err,
  input  wire  logic                      line_code_err,
  input  wire  logic                      line_false_carrier,
  input  wire  logic                      line_nib_stb,
  input  wire  logic [`MRX_NIB_W-1:0]     line_nib,
  // MII receive outputs
  output logic                            rx_clk,
  output logic                            rx_clk_oe_n,
  output logic [`MRX_NIB_W-1:0]           rx_data,
  output logic                            rx_data_oe_n,
  output logic                            rx_dv,
  output logic                            rx_dv_oe_n,
  output logic                            rx_er,
  output logic                            rx_er_oe_n,
  // MII transmit clock
  output logic                            tx_clk
);
  import mrx_pkg::*;

  // ****************************************
  // Line domain reset
  // ****************************************
  logic lrst_meta_q;
  logic lrst_n_q;

  always_ff @(posedge line_clk or negedge nrst) begin
    if (!nrst) begin
      lrst_meta_q <= 1'b0;
      lrst_n_q    <= 1'b0;
    end else begin
      lrst_meta_q <= 1'b1;
      lrst_n_q    <= lrst_meta_q;
    end
  end

  // ****************************************
  // Line domain framing
  // ****************************************
  mrx_ln_state_t ln_state_q;
  mrx_ln_state_t ln_state_d;
  mrx_ev_t       ev_q;
  mrx_ev_t       ev_d;
  logic          ev_fire;
  logic          ev_tgl_q;

  always_comb begin
    ln_state_d  = ln_state_q;
    ev_fire     = 1'b0;
    ev_d.kind   = MRX_EV_SOF;
    ev_d.nib    = line_nib;
    case (ln_state_q)
      MRX_LN_IDLE: begin
        if (line_ssd) begin
          ln_state_d = MRX_LN_FRAME; // see [RULE_09]
          ev_fire    = 1'b1;
        end else if (line_false_carrier) begin
          ev_fire    = 1'b1;
          ev_d.kind  = MRX_EV_FCAR; // see [RULE_14]
        end
      end
      MRX_LN_FRAME: begin
        if (line_sig_err) begin
          ln_state_d = MRX_LN_IDLE; // see [RULE_10]
          ev_fire    = 1'b1;
          ev_d.kind  = MRX_EV_ABORT;
        end else if (line_esd) begin
          ln_state_d = MRX_LN_IDLE; // see [RULE_10]
          ev_fire    = 1'b1;
          ev_d.kind  = MRX_EV_EOF;
        end else if (line_nib_stb) begin
          ev_fire    = 1'b1;
          ev_d.kind  = line_code_err ? MRX_EV_ERRNIB : MRX_EV_NIB; // see [RULE_13]
        end
      end
      default: begin
        ln_state_d = MRX_LN_IDLE;
      end
    endcase
  end

  always_ff @(posedge line_clk or negedge nrst) begin
    if (!nrst) begin
      ln_state_q <= MRX_LN_IDLE;
    end else if (!lrst_n_q) begin
      ln_state_q <= MRX_LN_IDLE;
    end else begin
      ln_state_q <= ln_state_d;
    end
  end

  // Held event word; it stays put until the next event, which the spacing
  // guarantee keeps clear of the far side's sampling
  always_ff @(posedge line_clk or negedge nrst) begin
    if (!nrst) begin
      ev_q     <= '{kind: MRX_EV_SOF, nib: `MRX_RST_NIB};
      ev_tgl_q <= 1'b0;
    end else if (lrst_n_q && ev_fire) begin
      ev_q     <= ev_d;
      ev_tgl_q <= ~ev_tgl_q;
    end
  end

  // ****************************************
  // Synchronisers into the system domain
  // ****************************************
  logic [4:0] sync_s1_q;
  logic [4:0] sync_s2_q;
  logic       tgl_s3_q;
  logic       crs_prev_q;
  logic       link_prev_q;
  logic       tgl_s2;
  logic       crs_s2;
  logic       link_s2;
  logic       spd_s2;
  logic       tri_s2;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync_s1_q   <= '0;
      sync_s2_q   <= '0;
      tgl_s3_q    <= 1'b0;
      crs_prev_q  <= 1'b0;
      link_prev_q <= 1'b0;
    end else begin
      sync_s1_q   <= {receive_output_tristate_ctl, speed_100,
                      line_link_ok, line_crs, ev_tgl_q};
      sync_s2_q   <= sync_s1_q;
      tgl_s3_q    <= tgl_s2;
      crs_prev_q  <= crs_s2;
      link_prev_q <= link_s2;
    end
  end

  assign tgl_s2  = sync_s2_q[0];
  assign crs_s2  = sync_s2_q[1];
  assign link_s2 = sync_s2_q[2];
  assign spd_s2  = sync_s2_q[3];
  assign tri_s2  = sync_s2_q[4];

  // ****************************************
  // Clock generation
  // ****************************************
  mrx_clk_if rx_if ();
  mrx_clk_if tx_if ();
  logic      restart_q;

  assign rx_if.fast    = spd_s2; // see [RULE_18]
  assign rx_if.restart = restart_q;
  assign tx_if.fast    = spd_s2; // see [RULE_17]
  assign tx_if.restart = 1'b0;
  assign rx_clk        = rx_if.clk_out;
  assign tx_clk        = tx_if.clk_out; // see [RULE_16]

  mrx_clk_div u_rx_div (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .ctl     (rx_if)
  );

  mrx_clk_div u_tx_div (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .ctl     (tx_if)
  );

  // Realignment of the receive clock phase. At 100 Mb/s without a link the divider simply
  // free-runs on the reference, which is what the MAC sees before bring-up.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      restart_q <= 1'b0;
    end else if (spd_s2) begin
      restart_q <= link_s2 & ~link_prev_q; // see [RULE_04] see [RULE_02] see [RULE_19]
    end else begin
      restart_q <= crs_s2 & ~crs_prev_q & ~rx_dv; // see [RULE_01] see [RULE_03]
    end
  end

  // ****************************************
  // Pending event slot
  // ****************************************
  logic    new_ev;
  logic    pend_q;
  mrx_ev_t pend_ev_q;

  assign new_ev = tgl_s2 ^ tgl_s3_q;

  // A new event wins over the consumption of the old one in the same cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pend_q    <= 1'b0;
      pend_ev_q <= '{kind: MRX_EV_SOF, nib: `MRX_RST_NIB};
    end else if (new_ev) begin
      pend_q    <= 1'b1;
      pend_ev_q <= ev_q;
    end else if (rx_if.fall) begin
      pend_q    <= 1'b0;
    end
  end

  // ****************************************
  // Receive outputs
  // ****************************************
  // Updated only on the cycle after a falling edge of rx_clk, so each value
  // is stable across the next rising edge where the MAC samples it
  logic drop_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_dv   <= 1'b0;
      rx_er   <= 1'b0;
      rx_data <= `MRX_RST_NIB;
      drop_q  <= 1'b0;
    end else if (rx_if.fall) begin // see [RULE_11] see [RULE_15] see [RULE_07]
      rx_er <= 1'b0;
      if (pend_q) begin
        case (pend_ev_q.kind)
          MRX_EV_NIB: begin
            rx_dv   <= 1'b1; // see [RULE_08]
            rx_data <= pend_ev_q.nib[`MRX_NIB_MSB:`MRX_NIB_LSB]; // see [RULE_06]
          end
          MRX_EV_ERRNIB: begin
            rx_dv   <= 1'b1;
            rx_data <= pend_ev_q.nib[`MRX_NIB_MSB:`MRX_NIB_LSB];
            rx_er   <= spd_s2; // see [RULE_13] see [RULE_12]
          end
          MRX_EV_ABORT: begin
            rx_er   <= spd_s2 & rx_dv; // see [RULE_13] see [RULE_12]
            drop_q  <= 1'b1;
          end
          MRX_EV_EOF: begin
            rx_dv   <= 1'b0; // see [RULE_10]
          end
          MRX_EV_FCAR: begin
            rx_dv   <= 1'b0;
            rx_er   <= spd_s2; // see [RULE_14] see [RULE_12]
          end
          default: begin
            rx_dv   <= rx_dv;
          end
        endcase
      end else if (drop_q) begin
        rx_dv  <= 1'b0; // see [RULE_10]
        drop_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Output enables
  // ****************************************
  // Data and valid float together with clock and error, so a shared bus sees no stray frame
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_clk_oe_n  <= `MRX_RST_OE_N;
      rx_er_oe_n   <= `MRX_RST_OE_N;
      rx_data_oe_n <= `MRX_RST_OE_N;
      rx_dv_oe_n   <= `MRX_RST_OE_N;
    end else begin
      rx_clk_oe_n  <= tri_s2; // see [RULE_05]
      rx_er_oe_n   <= tri_s2; // see [RULE_05]
      rx_data_oe_n <= tri_s2;
      rx_dv_oe_n   <= tri_s2;
    end
  end

endmodule

// ==== tb/mrx_mac_model.sv ====
// Receiving MAC on the MII: keeps the last captured nibble and counts error periods.
// Assumes pin levels are already resolved by the bench.
`timescale 1ns/10ps

module mrx_mac_model (
  // MII receive pins
  input wire logic       rx_clk,
  input wire logic [3:0] rx_data,
  input wire logic       rx_dv,
  input wire logic       rx_er
);
  logic [4:0] last_q;
  int         er_cnt;
  initial begin
    last_q = 5'h00;
    er_cnt = 0;
  end
  // Rising edges only; the device moves its pins while the clock is low
  always @(posedge rx_clk) begin
    if (rx_dv === 1'b1) last_q <= {rx_er, rx_data};
    if (rx_er === 1'b1) er_cnt <= er_cnt + 1;
  end
endmodule

// ==== tb/mrx_rx_top_properties.sv ====
// Checker of the MII device end, watching only the top ports.
// Assumes sys_clk at 100 MHz; bound to mrx_rx_top at the foot.
`timescale 1ns/10ps
`include "mrx_consts.svh"

module mrx_rx_top_properties (
  // Clock, reset and pins
  input wire logic                  sys_clk,
  input wire logic                  nrst,
  input wire logic                  speed_100,
  input wire logic                  receive_output_tristate_ctl,
  // MII outputs
  input wire logic                  rx_clk,
  input wire logic                  rx_clk_oe_n,
  input wire logic [`MRX_NIB_W-1:0] rx_data,
  input wire logic                  rx_data_oe_n,
  input wire logic                  rx_dv,
  input wire logic                  rx_dv_oe_n,
  input wire logic                  rx_er,
  input wire logic                  rx_er_oe_n,
  input wire logic                  tx_clk
);
  localparam int FAST_HALF = 2;
  localparam int SLOW_HALF = 20;
  // ****
  // Helpers; the speed pin is synced, so judge clocks only once it has been calm
  // ****
  logic [6:0] calm_q;
  logic [5:0] hi_q;
  logic [5:0] still_q;
  logic [2:0] age_q;
  logic       spd_q;
  logic       tx_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      calm_q  <= 7'h00;
      hi_q    <= 6'h00;
      still_q <= 6'h00;
      age_q   <= 3'h0;
      spd_q   <= 1'b0;
      tx_q    <= 1'b0;
    end else begin
      spd_q   <= speed_100;
      tx_q    <= tx_clk;
      calm_q  <= (speed_100 != spd_q) ? 7'h00 : calm_q + {6'h00, ~&calm_q};
      hi_q    <= tx_clk ? hi_q + 6'h01 : 6'h00;
      still_q <= (tx_clk != tx_q) ? 6'h00 : still_q + 6'h01;
      age_q   <= age_q + {2'h0, ~&age_q};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ****
  // Properties
  // ****
  chk_dv_sync: assert property ($changed(rx_dv) |-> !rx_clk)
    else $error("rx_dv changed while rx_clk high");
  chk_er_sync: assert property ($changed(rx_er) |-> !rx_clk)
    else $error("rx_er changed while rx_clk high");
  chk_data_sync: assert property ($changed(rx_data) |-> !rx_clk)
    else $error("rx_data changed while rx_clk high");
  chk_er_slow_quiet: assert property (!speed_100 && calm_q == 7'h7f |-> !rx_er)
    else $error("rx_er raised at 10 Mb/s");
  chk_er_one_period: assert property (
    $rose(rx_er) && speed_100 && calm_q == 7'h7f |-> rx_er [*4] ##1 !rx_er)
    else $error("rx_er pulse not one rx_clk period");
  chk_tx_half_period: assert property (
    $fell(tx_clk) && calm_q == 7'h7f |-> hi_q == (speed_100 ? FAST_HALF : SLOW_HALF))
    else $error("tx_clk high phase wrong");
  chk_tx_keeps_running: assert property (still_q <= 6'd24)
    else $error("tx_clk stopped");
  chk_oe_follow_pin: assert property (age_q[2] |->
    {rx_clk_oe_n, rx_data_oe_n, rx_dv_oe_n, rx_er_oe_n}
      == {4{$past(receive_output_tristate_ctl, 3)}})
    else $error("output enables do not follow tristate pin");
endmodule

bind mrx_rx_top mrx_rx_top_properties chk (
  .sys_clk(sys_clk), .nrst(nrst), .speed_100(speed_100),
  .receive_output_tristate_ctl(receive_output_tristate_ctl),
  .rx_clk(rx_clk), .rx_clk_oe_n(rx_clk_oe_n), .rx_data(rx_data),
  .rx_data_oe_n(rx_data_oe_n), .rx_dv(rx_dv), .rx_dv_oe_n(rx_dv_oe_n),
  .rx_er(rx_er), .rx_er_oe_n(rx_er_oe_n), .tx_clk(tx_clk)
);

// ==== tb/mrx_rx_top_bench.sv ====
// Self-checking bench of the MII device end with a receiving MAC model.
// Assumes the design package and header compile first.
`timescale 1ns/10ps

module mrx_rx_top_bench;
  import mrx_pkg::*;
  localparam logic [5:0] EV_SSD = 6'h20, EV_ESD = 6'h10, EV_SER = 6'h08;
  localparam logic [5:0] EV_FC = 6'h04, EV_NIB = 6'h02, EV_CE = 6'h03;
  logic       sys_clk, nrst, speed_100, receive_output_tristate_ctl, line_clk;
  logic       line_link_ok, line_crs, line_ssd, line_esd, line_sig_err, line_code_err;
  logic       line_false_carrier, line_nib_stb;
  logic [3:0] line_nib, rx_data;
  logic [5:0] ev_q;
  logic       rx_clk, rx_clk_oe_n, rx_data_oe_n, rx_dv, rx_dv_oe_n, rx_er, rx_er_oe_n, tx_clk;
  int         fails, compares;
  assign {line_ssd, line_esd, line_sig_err, line_false_carrier, line_nib_stb, line_code_err} = ev_q;
  // Released pins show the inverse of the last value, never a friendly level
  wire logic       mii_clk  = rx_clk_oe_n ? ~rx_clk : rx_clk;
  wire logic [3:0] mii_data = rx_data_oe_n ? ~rx_data : rx_data;
  wire logic       mii_dv   = rx_dv_oe_n ? ~rx_dv : rx_dv;
  wire logic       mii_er   = rx_er_oe_n ? ~rx_er : rx_er;

  mrx_rx_top uut (.sys_clk(sys_clk), .nrst(nrst), .speed_100(speed_100),
    .receive_output_tristate_ctl(receive_output_tristate_ctl), .line_clk(line_clk),
    .line_link_ok(line_link_ok), .line_crs(line_crs), .line_ssd(line_ssd),
    .line_esd(line_esd), .line_sig_err(line_sig_err), .line_code_err(line_code_err),
    .line_false_carrier(line_false_carrier), .line_nib_stb(line_nib_stb),
    .line_nib(line_nib), .rx_clk(rx_clk), .rx_clk_oe_n(rx_clk_oe_n), .rx_data(rx_data),
    .rx_data_oe_n(rx_data_oe_n), .rx_dv(rx_dv), .rx_dv_oe_n(rx_dv_oe_n), .rx_er(rx_er),
    .rx_er_oe_n(rx_er_oe_n), .tx_clk(tx_clk));
  mrx_mac_model mac (.rx_clk(mii_clk), .rx_data(mii_data), .rx_dv(mii_dv), .rx_er(mii_er));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    line_clk = 1'b0;
    #3.7;
    forever #7.5 line_clk = ~line_clk;
  end
  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One line event, then room for the crossing and one rx_clk period
  task automatic lev(input logic [5:0] ev, input logic [3:0] n);
    @(posedge line_clk);
    #1;
    ev_q = ev;
    line_nib = n;
    @(posedge line_clk);
    #1;
    ev_q = 6'h00;
    repeat (speed_100 ? 10 : 40) @(posedge line_clk);
    #1;
  endtask
  // Sys cycles between two rising edges of tx_clk (sel 0) or rx_clk (sel 1)
  task automatic period(input logic sel, input logic [7:0] exp);
    logic p;
    int   n;
    int   e;
    p = 1'b1;
    n = 0;
    e = 0;
    repeat (200) begin
      @(negedge sys_clk);
      if (e == 1) n++;
      if ((sel ? rx_clk : tx_clk) === 1'b1 && p === 1'b0) e++;
      if (e == 2) break;
      p = sel ? rx_clk : tx_clk;
    end
    if (e < 2) begin
      fails++;
      summarize();
    end else check(n[7:0], exp);
  endtask
  // ****
  // Scenarios
  // ****
  // Returns just after the sys edge at which rx_clk has risen
  task automatic rise_sync;
    logic p;
    int   i;
    p = 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge sys_clk);
      #1;
      if (rx_clk === 1'b1 && p === 1'b0) break;
      p = rx_clk;
    end
    if (i == 100) begin
      fails++;
      summarize();
    end
  endtask
  // A realignment forces a fresh low phase; a free-running clock would be high here
  task automatic t_clocks_fast;
    period(1'b1, 8'd4);
    rise_sync();
    line_link_ok = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    check({7'h00, rx_clk}, 8'h00);
    repeat (15) @(posedge sys_clk);
    period(1'b1, 8'd4);
    period(1'b0, 8'd4);
    $display("done: clocks at 100 Mb/s");
  endtask
  task automatic t_frame_fast;
    logic [3:0] n;
    lev(EV_NIB, 4'h5);
    check({3'h0, rx_dv, 4'h0}, 8'h00);
    lev(EV_SSD, 4'h0);
    for (int i = 0; i < 4; i++) begin
      n = 4'h1 << i;
      lev(EV_NIB, n);
      check({3'h0, rx_dv, rx_data}, {4'h1, n});
      check({3'h0, mac.last_q}, {4'h0, n});
    end
    lev(EV_ESD, 4'h0);
    check({7'h00, rx_dv}, 8'h00);
    $display("done: frame at 100 Mb/s");
  endtask
  task automatic t_errors_fast;
    int e0;
    e0 = mac.er_cnt;
    lev(EV_SSD, 4'h0);
    lev(EV_CE, 4'hc);
    check({3'h0, rx_dv, rx_data}, 8'h1c);
    check(8'(mac.er_cnt - e0), 8'h01);
    lev(EV_SER, 4'h0);
    check({3'h0, rx_dv, 4'(mac.er_cnt - e0)}, 8'h02);
    lev(EV_FC, 4'h0);
    check({3'h0, rx_dv, 4'(mac.er_cnt - e0)}, 8'h03);
    $display("done: errors at 100 Mb/s");
  endtask
  task automatic t_tristate;
    @(posedge sys_clk);
    #1;
    receive_output_tristate_ctl = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    check({4'h0, rx_clk_oe_n, rx_data_oe_n, rx_dv_oe_n, rx_er_oe_n}, 8'h0f);
    receive_output_tristate_ctl = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    check({4'h0, rx_clk_oe_n, rx_data_oe_n, rx_dv_oe_n, rx_er_oe_n}, 8'h00);
    $display("done: tristate");
  endtask
  task automatic t_slow;
    int e0;
    @(posedge sys_clk);
    #1;
    speed_100 = 1'b0;
    repeat (200) @(posedge sys_clk);
    period(1'b0, 8'd40);
    period(1'b1, 8'd40);
    e0 = mac.er_cnt;
    rise_sync();
    line_crs = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    check({7'h00, rx_clk}, 8'h00);
    lev(EV_SSD, 4'h0);
    lev(EV_NIB, 4'h9);
    lev(EV_CE, 4'h6);
    check({3'h0, mac.last_q}, 8'h06);
    lev(EV_ESD, 4'h0);
    line_crs = 1'b0;
    lev(EV_FC, 4'h0);
    check({3'h0, rx_dv, 4'(mac.er_cnt - e0)}, 8'h00);
    $display("done: 10 Mb/s");
  endtask

  initial begin
    fails = 0;
    compares = 0;
    nrst = 1'b0;
    speed_100 = 1'b1;
    receive_output_tristate_ctl = 1'b0;
    line_link_ok = 1'b0;
    line_crs = 1'b0;
    ev_q = 6'h00;
    line_nib = 4'h0;
    repeat (16) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    t_clocks_fast();
    t_frame_fast();
    t_errors_fast();
    t_tristate();
    t_slow();
    summarize();
  end
endmodule
